// >>> inc/ctmc_pkg.sv
// Purpose: Shared constants and types for the charge-time measure control block.
// Assumes: An 8-bit register port with a three-bit word address.
// Notes: Every offset and register layout used by the logic lives here, with the 8-bit register reset value RST_REG.
package ctmc_pkg;

    // Register port widths.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_LOW = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CURRENT = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;

    // Reset values: every register clears.
    localparam logic [DATA_W-1:0] RST_REG = 8'h00;

    // Number of edge sources and interrupt events.
    localparam int NUM_SRC = 4;
    localparam int NUM_EVT = 4;

    // Interrupt event positions.
    localparam int EVT_EDGE_ONE = 0;
    localparam int EVT_EDGE_TWO = 1;
    localparam int EVT_PULSE_DONE = 2;
    localparam int EVT_ABORT = 3;

    // Current range code that switches the source off.
    localparam logic [1:0] RANGE_OFF = 2'h0;

    // Control high register layout, bit 7 first.
    typedef struct packed {
        logic enable;
        logic unused6;
        logic idle_stop_select;
        logic delay_gen_enable;
        logic edge_pass_enable;
        logic edge_order_enable;
        logic source_ground_control;
        logic trig_enable;
    } ctmc_ctrl_high_type;

    // Control low register layout, bit 7 first.
    typedef struct packed {
        logic edge_two_pol;
        logic [1:0] edge_two_sel;
        logic edge_one_pol;
        logic [1:0] edge_one_sel;
        logic edge_two_flag;
        logic edge_one_flag;
    } ctmc_ctrl_low_type;

    // Current control register layout.
    typedef struct packed {
        logic [5:0] trim;
        logic [1:0] range;
    } ctmc_current_type;

endpackage : ctmc_pkg

// >>> rtl/ctmc_charge_time_unit.sv
// Purpose: Digital control of the charge-time unit: edge flags, current source gating,
// delay pulse generation, low-power gating and interrupts.
// Assumes: All inputs are synchronous to i_clk_sys; edge sources are levels.
// Notes: Register reads return data in the cycle after the read strobe.
// Edge flags may also be written by software; a hardware event wins a same-cycle clear.
// The comparator trip stands in for edge two while delay generation is on.
`timescale 1ns/1ps

module ctmc_charge_time_unit (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Register port.
    input wire logic [ctmc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ctmc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ctmc_pkg::DATA_W-1:0] o_rdata,
    // Edge sources, comparator and power state.
    input wire logic [ctmc_pkg::NUM_SRC-1:0] i_edge_src,
    input wire logic i_cmp_trip,
    input wire logic i_sleep,
    input wire logic i_idle,
    // Analog control and trigger outputs.
    output logic o_current_enable,
    output logic [1:0] o_current_range,
    output logic [5:0] o_current_trim,
    output logic o_source_ground,
    output logic o_pulse_out,
    output logic o_adc_trigger,
    // Interrupt.
    output logic o_irq
);

    logic [1:0] rst_sync;
    logic rst_n;
    ctmc_pkg::ctmc_ctrl_high_type ctrl_h;
    ctmc_pkg::ctmc_ctrl_low_type ctrl_l;
    ctmc_pkg::ctmc_current_type cur;
    logic [ctmc_pkg::NUM_EVT-1:0] irq_status;
    logic [ctmc_pkg::NUM_EVT-1:0] irq_mask;
    logic [ctmc_pkg::NUM_SRC-1:0] src_q;
    logic pd_q;

    // Reset release through two flip-flops.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Address decode of the register port.
    wire wr_high = i_wr && (i_addr == ctmc_pkg::OFS_CTRL_HIGH);
    wire wr_low = i_wr && (i_addr == ctmc_pkg::OFS_CTRL_LOW);
    wire wr_cur = i_wr && (i_addr == ctmc_pkg::OFS_CURRENT);
    wire wr_stat = i_wr && (i_addr == ctmc_pkg::OFS_IRQ_STATUS);
    wire wr_mask = i_wr && (i_addr == ctmc_pkg::OFS_IRQ_MASK);
    ctmc_pkg::ctmc_ctrl_low_type wlow;
    assign wlow = i_wdata;
    ctmc_pkg::ctmc_ctrl_high_type whigh;
    assign whigh = i_wdata;

    // Control high write value; bit 6 is not implemented and always reads zero.
    ctmc_pkg::ctmc_ctrl_high_type next_high;
    always_comb begin
        next_high = whigh;
        next_high.unused6 = 1'b0;
    end

    // Edge detection per source; polarity picks rising or falling.
    wire [ctmc_pkg::NUM_SRC-1:0] rise = i_edge_src & ~src_q;
    wire [ctmc_pkg::NUM_SRC-1:0] fall = ~i_edge_src & src_q;
    wire hit_one = ctrl_l.edge_one_pol ? rise[ctrl_l.edge_one_sel] : fall[ctrl_l.edge_one_sel];
    wire hit_two = ctrl_l.edge_two_pol ? rise[ctrl_l.edge_two_sel] : fall[ctrl_l.edge_two_sel];

    // Low-power gating: Sleep always, Idle only when stop is selected.
    // Idle without stop selected keeps running.
    wire idle_stop = i_idle && ctrl_h.idle_stop_select;
    wire powered_down = i_sleep || idle_stop;

    // Charging request from the flags, before low-power gating.
    wire charge_req = ctrl_h.enable && ctrl_l.edge_one_flag && !ctrl_l.edge_two_flag;

    // Delay mode: the comparator trip while charging acts as the second edge.
    // Using the comparator instead of a timer keeps the pulse width set by the capacitor.
    wire pulse_trip = ctrl_h.delay_gen_enable && charge_req && i_cmp_trip;

    // Accepted edge events, passed only while edge pass enable is set; edge order blocks edge two only, the pulse trip bypasses both.
    wire evt_one = ctrl_h.enable && ctrl_h.edge_pass_enable && hit_one;
    wire order_ok = !ctrl_h.edge_order_enable || ctrl_l.edge_one_flag;
    wire evt_two = (ctrl_h.enable && ctrl_h.edge_pass_enable && hit_two && order_ok)
                   || pulse_trip;

    // Abort: the source is cut while a charge is in progress.
    // Only the entry into power-down is flagged, so a long Sleep raises one event.
    wire evt_abort = charge_req && powered_down && !pd_q;
    wire [ctmc_pkg::NUM_EVT-1:0] events = {evt_abort, pulse_trip, evt_two, evt_one};

    // Write-one-to-clear mask for the status register.
    wire [ctmc_pkg::NUM_EVT-1:0] stat_clear = wr_stat ? i_wdata[ctmc_pkg::NUM_EVT-1:0] : '0;

    // Next values of the edge flags; an event wins over a software clear.
    wire next_flag_one = (wr_low ? wlow.edge_one_flag : ctrl_l.edge_one_flag) || evt_one;
    wire next_flag_two = (wr_low ? wlow.edge_two_flag : ctrl_l.edge_two_flag) || evt_two;

    // Next value of the current source enable.
    // A zero range code also holds the source off, so no charge flows unasked.
    wire next_current = charge_req && !powered_down && (cur.range != ctmc_pkg::RANGE_OFF);

    // Read data selection; unmapped offsets read as zero.
    logic [ctmc_pkg::DATA_W-1:0] rd_sel;
    assign rd_sel = (i_addr == ctmc_pkg::OFS_CTRL_HIGH) ? ctrl_h :
                    (i_addr == ctmc_pkg::OFS_CTRL_LOW) ? ctrl_l :
                    (i_addr == ctmc_pkg::OFS_CURRENT) ? cur :
                    (i_addr == ctmc_pkg::OFS_IRQ_STATUS) ? {4'h0, irq_status} :
                    (i_addr == ctmc_pkg::OFS_IRQ_MASK) ? {4'h0, irq_mask} :
                    ctmc_pkg::RST_REG;

    // Control registers, cleared by any reset.
    // reset clears all.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_h <= ctmc_pkg::RST_REG;
            ctrl_l <= ctmc_pkg::RST_REG;
            cur <= ctmc_pkg::RST_REG;
            irq_mask <= 4'h0;
        end else begin
            if (wr_high) begin
                ctrl_h <= next_high;
            end
            if (wr_low) begin
                ctrl_l[7:2] <= wlow[7:2];
            end
            ctrl_l.edge_one_flag <= next_flag_one;
            ctrl_l.edge_two_flag <= next_flag_two;
            if (wr_cur) begin
                cur <= i_wdata;
            end
            if (wr_mask) begin
                irq_mask <= i_wdata[ctmc_pkg::NUM_EVT-1:0];
            end
        end
    end

    // Sticky interrupt status; set wins over a write-one clear.
    // abort is reported.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= (irq_status & ~stat_clear) | events;
        end
    end

    // Source history and power-down history.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= 4'h0;
            pd_q <= 1'b0;
        end else begin
            src_q <= i_edge_src;
            pd_q <= powered_down;
        end
    end

    // Current enable, source ground and pulse outputs, all registered.
    // charge window, power gating.
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_current_enable <= 1'b0;
            o_source_ground <= 1'b0;
            o_pulse_out <= 1'b0;
            o_adc_trigger <= 1'b0;
            o_rdata <= ctmc_pkg::RST_REG;
        end else begin
            o_current_enable <= next_current;
            o_source_ground <= ctrl_h.source_ground_control;
            // pulse spans the charge to the trip.
            o_pulse_out <= ctrl_h.delay_gen_enable && next_current && !pulse_trip;
            o_adc_trigger <= ctrl_h.trig_enable && evt_two;
            o_rdata <= i_rd ? rd_sel : ctmc_pkg::RST_REG;
        end
    end

    // Current range and trim go straight to the analog source.
    assign o_current_range = cur.range;
    assign o_current_trim = cur.trim;

    // Level interrupt while any unmasked status bit is set.
    assign o_irq = |(irq_status & irq_mask);

    // Checks run in the released reset domain.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Named steps of a delay pulse: a trip, then the flag, then the pulse falls.
    sequence s_trip;
        pulse_trip;
    endsequence
    sequence s_pulse_end;
        ctrl_l.edge_two_flag ##1 !o_pulse_out;
    endsequence

    a_sleep_source_off: assert property (i_sleep |=> !o_current_enable)
        else $error("Current source on during Sleep.");

    a_idle_stop_off: assert property (i_idle && ctrl_h.idle_stop_select |=> !o_current_enable)
        else $error("Current source on in Idle with stop selected.");

    a_idle_keeps_running: assert property (i_idle && !ctrl_h.idle_stop_select && !i_sleep
        && charge_req && cur.range != ctmc_pkg::RANGE_OFF |=> o_current_enable)
        else $error("Current source stopped in Idle without stop selected.");

    a_charge_window: assert property (o_current_enable
        |-> $past(ctrl_l.edge_one_flag) && !$past(ctrl_l.edge_two_flag))
        else $error("Current source on outside the charge window.");

    a_ground_write: assert property (wr_high && whigh.source_ground_control
        |=> ##1 o_source_ground)
        else $error("Source ground not applied after write.");

    a_edges_blocked: assert property (!ctrl_h.edge_pass_enable && !wr_low
        && !pulse_trip |=> $stable({ctrl_l.edge_two_flag, ctrl_l.edge_one_flag}))
        else $error("Blocked edge changed a flag.");

    a_order_two: assert property (ctrl_h.edge_order_enable && !ctrl_l.edge_one_flag
        && !ctrl_l.edge_two_flag && !wr_low |=> !ctrl_l.edge_two_flag)
        else $error("Edge two accepted before edge one.");

    a_pulse_trip_end: assert property (s_trip |=> s_pulse_end)
        else $error("Pulse did not end at the comparator trip.");

    a_pulse_mode_only: assert property (o_pulse_out |-> $past(ctrl_h.delay_gen_enable))
        else $error("Pulse output outside delay generation mode.");

    a_abort_flagged: assert property (evt_abort |=> irq_status[ctmc_pkg::EVT_ABORT])
        else $error("Abort event not recorded.");

    a_reset_clear: assert property ($rose(rst_n) |-> ctrl_h == ctmc_pkg::RST_REG
        && !o_current_enable)
        else $error("Control not cleared after reset.");

    // Named step of a charge start in delay mode.
    sequence s_charge_start;
        ctrl_h.delay_gen_enable && next_current && !pulse_trip;
    endsequence

    a_pulse_start: assert property (s_charge_start |=> o_pulse_out)
        else $error("Pulse did not start with the charge.");

    a_ground_release: assert property (wr_high && !whigh.source_ground_control
        |=> ##1 !o_source_ground)
        else $error("Source ground held after clear.");

    a_flag_one_set: assert property (evt_one |=> ctrl_l.edge_one_flag)
        else $error("Passed edge one did not set its flag.");

    a_order_accept: assert property (ctrl_h.enable && ctrl_h.edge_pass_enable
        && ctrl_h.edge_order_enable && ctrl_l.edge_one_flag && hit_two |=> ctrl_l.edge_two_flag)
        else $error("Edge two refused after edge one.");

    a_disabled_off: assert property (!ctrl_h.enable |=> !o_current_enable)
        else $error("Current source on while the unit is disabled.");

    a_range_off: assert property (cur.range == ctmc_pkg::RANGE_OFF
        |=> !o_current_enable)
        else $error("Current source on with range off.");

    a_status_sticky: assert property (irq_status[ctmc_pkg::EVT_PULSE_DONE]
        && !stat_clear[ctmc_pkg::EVT_PULSE_DONE] |=> irq_status[ctmc_pkg::EVT_PULSE_DONE])
        else $error("Pulse status bit lost without a clear.");

    a_sleep_no_pulse: assert property (i_sleep |=> !o_pulse_out)
        else $error("Pulse output high during Sleep.");

    a_trig_edge_two: assert property (ctrl_h.trig_enable && evt_two |=> o_adc_trigger)
        else $error("Conversion trigger missing after edge two.");

endmodule : ctmc_charge_time_unit

// >>> testbench/ctmc_cap_model.sv
// Purpose: Behavioural capacitor and comparator beside the charge-time unit.
// Assumes: One charge step per clock while the current source is on.
// Notes: TRIP_CYC is short so that pulse runs stay brief.
`timescale 1ns/1ps
module ctmc_cap_model #(
    parameter int TRIP_CYC = 6
) (
    // Clock.
    input wire logic i_clk_sys,
    // Analog controls from the unit.
    input wire logic i_current_enable,
    input wire logic i_source_ground,
    // Comparator result.
    output logic o_cmp_trip
);
    // unused channel: the node holds only stray capacitance and the cap.
    int charge = 0;
    // grounded node drains
    // Charge builds while the source is on and drains while the output is grounded.
    always @(posedge i_clk_sys) begin
        if (i_source_ground) begin
            charge <= 0;
        end else if (i_current_enable) begin
            charge <= charge + 1;
        end
    end
    // reference trip point
    // The comparator trips once the node voltage reaches the reference.
    assign o_cmp_trip = (charge >= TRIP_CYC);
endmodule : ctmc_cap_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the charge-time unit control.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: A small capacitor model closes the comparator loop.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic i_clk_sys = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
    logic i_sleep = 0, i_idle = 0, cmp_trip;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, rv;
    logic [3:0] i_edge_src = 0;
    logic o_current_enable, o_source_ground, o_pulse_out, o_irq, o_adc_trigger;
    logic [1:0] o_current_range;
    logic [5:0] o_current_trim;
    int error_cnt = 0, compares = 0, trig_cnt = 0;
    ctmc_charge_time_unit uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_edge_src(i_edge_src), .i_cmp_trip(cmp_trip), .i_sleep(i_sleep),
        .i_idle(i_idle), .o_current_enable(o_current_enable),
        .o_current_range(o_current_range), .o_current_trim(o_current_trim),
        .o_source_ground(o_source_ground), .o_pulse_out(o_pulse_out),
        .o_adc_trigger(o_adc_trigger), .o_irq(o_irq));
    // Counts conversion trigger pulses.
    always @(posedge i_clk_sys) begin
        if (o_adc_trigger === 1'b1) trig_cnt++;
    end
    ctmc_cap_model model (.i_clk_sys(i_clk_sys), .i_current_enable(o_current_enable),
        .i_source_ground(o_source_ground), .o_cmp_trip(cmp_trip));
    // Clock at 40 MHz.
    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // One-cycle register write and read.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
        @(posedge i_clk_sys) i_wr <= 0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge i_clk_sys) begin i_rd <= 1; i_addr <= a; end
        @(posedge i_clk_sys) i_rd <= 0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : wait_cyc
    // Registers clear on reset, unmapped places read zero.
    task automatic t_reset;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            `CHK(rv, 8'h00)
        end
        wr(3'h6, 8'hFF);
        rd(3'h6);
        `CHK(rv, 8'h00)
        `CHK(o_current_enable, 1'b0)
        $display("t_reset done");
    endtask : t_reset
    // Software charge sequence and grounding.
    task automatic t_charge;
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h82);
        wait_cyc(2);
        `CHK(o_source_ground, 1'b1)
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h80);
        wait_cyc(2);
        `CHK(o_source_ground, 1'b0)
        wr(ctmc_pkg::OFS_CURRENT, 8'h01);
        #1 `CHK({o_current_trim, o_current_range}, 8'h01)
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h01);
        wait_cyc(2);
        `CHK(o_current_enable, 1'b1)
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h03);
        wait_cyc(2);
        `CHK(o_current_enable, 1'b0)
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h00);
        wait_cyc(2);
        `CHK(o_current_enable, 1'b0)
        $display("t_charge done");
    endtask : t_charge
    // Raise one edge source for three cycles and read the flags back.
    task automatic pulse_src(input int s, input logic [7:0] exp);
        @(posedge i_clk_sys) i_edge_src[s] <= 1;
        wait_cyc(2);
        @(posedge i_clk_sys) i_edge_src[s] <= 0;
        wait_cyc(2);
        rd(ctmc_pkg::OFS_CTRL_LOW);
        `CHK(rv, exp)
    endtask : pulse_src
    // Blocked edges and edge order.
    task automatic t_edges;
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h80);
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'hB0);
        pulse_src(0, 8'hB0);
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h8D);
        pulse_src(1, 8'hB0);
        pulse_src(0, 8'hB1);
        pulse_src(1, 8'hB3);
        `CHK(trig_cnt, 1)
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h00);
        $display("t_edges done");
    endtask : t_edges
    // Delay pulse ends at the comparator trip and raises an interrupt.
    task automatic t_pulse;
        wr(ctmc_pkg::OFS_IRQ_STATUS, 8'h0F);
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h82);
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h90);
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h01);
        wait_cyc(2);
        `CHK(o_pulse_out, 1'b1)
        wait_cyc(12);
        `CHK(o_pulse_out, 1'b0)
        rd(ctmc_pkg::OFS_IRQ_STATUS);
        `CHK(rv & 8'h04, 8'h04)
        wr(ctmc_pkg::OFS_IRQ_MASK, 8'h04);
        #1 `CHK(o_irq, 1'b1)
        wr(ctmc_pkg::OFS_IRQ_STATUS, 8'h04);
        #1 `CHK(o_irq, 1'b0)
        $display("t_pulse done");
    endtask : t_pulse
    // Sleep and Idle gating of the current source.
    task automatic t_power;
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h82);
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'h80);
        wr(ctmc_pkg::OFS_CTRL_LOW, 8'h01);
        wait_cyc(2);
        @(posedge i_clk_sys) i_sleep <= 1;
        wait_cyc(2);
        `CHK(o_current_enable, 1'b0)
        rd(ctmc_pkg::OFS_IRQ_STATUS);
        `CHK(rv & 8'h08, 8'h08)
        @(posedge i_clk_sys) begin i_sleep <= 0; i_idle <= 1; end
        wait_cyc(3);
        `CHK(o_current_enable, 1'b1)
        wr(ctmc_pkg::OFS_CTRL_HIGH, 8'hA0);
        wait_cyc(2);
        `CHK(o_current_enable, 1'b0)
        $display("t_power done");
    endtask : t_power
    // Reset in mid-run clears every register and output.
    task automatic t_rereset;
        wr(ctmc_pkg::OFS_IRQ_MASK, 8'h0F);
        @(posedge i_clk_sys) i_reset_n <= 0;
        @(posedge i_clk_sys) i_reset_n <= 1;
        wait_cyc(3);
        `CHK(o_current_enable, 1'b0)
        `CHK(o_irq, 1'b0)
        `CHK({o_current_trim, o_current_range}, 8'h00)
        rd(ctmc_pkg::OFS_CTRL_HIGH);
        `CHK(rv, 8'h00)
        rd(ctmc_pkg::OFS_IRQ_MASK);
        `CHK(rv, 8'h00)
        $display("t_rereset done");
    endtask : t_rereset
    task automatic summarize;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // Main sequence.
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1;
        wait_cyc(3);
        t_reset();
        t_charge();
        t_edges();
        t_pulse();
        t_power();
        t_rereset();
        summarize();
    end
    // Watchdog for a hung run.
    initial begin
        #(25 * 5000);
        error_cnt++;
        summarize();
    end
endmodule : testbench
